/* design/coder_pkg.sv */
`default_nettype none
package coder_pkg;
  // Register offsets on the configuration port
  localparam logic [6:0] CHIP_RATE_HIGH_ADDR = 7'h03;
  localparam logic [6:0] CHIP_RATE_LOW_ADDR = 7'h04;
  // Register reset values
  localparam logic [7:0] CHIP_RATE_HIGH_RST = 8'h1a;
  localparam logic [7:0] CHIP_RATE_LOW_RST = 8'h0b;
  // Line coding selector codes
  localparam logic [1:0] DC_NONE = 2'h0;
  localparam logic [1:0] DC_MANCHESTER = 2'h1;
  localparam logic [1:0] DC_WHITENING = 2'h2;
  // Checksum generator, preset and length in bytes
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_PRESET = 16'h1d0f;
  localparam logic [8:0] CRC_BYTES = 9'h002;
  // Whitening register preset and tap
  localparam logic [8:0] LFSR_PRESET = 9'h1ff;
  localparam int LFSR_TAP = 5;
  // Bit index bounds inside a byte
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int MSB = 7;
  // Static configuration carried as one group
  typedef struct packed {
    logic packet_mode;          // Packet mode, not continuous
    logic [1:0] dc_balance_select; // Line coding selector
    logic checksum_enable;      // Append and check checksum
    logic crc_fail_keep_fifo;   // Keep buffer on checksum failure
  } cfg_s;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TX_FETCH = 3'b001,
    ST_TX_LOAD = 3'b010,
    ST_TX_BITS = 3'b011,
    ST_RX_BITS = 3'b100
  } state_e;
endpackage
`default_nettype wire

/* design/payload_crc_dc_balance_select_coder.sv */
`default_nettype none
module payload_crc_dc_balance_select_coder #(
  parameter int AW = 6
) (
  // Clock and synchronous reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Static configuration
  input wire coder_pkg::cfg_s cfg,
  // Host buffer access
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  input wire logic flag_clear,
  output logic payload_available_flag,
  output logic checksum_match_flag,
  // Packet control, payload length in bytes
  input wire logic tx_start,
  input wire logic rx_start,
  input wire logic [7:0] pkt_len,
  output logic busy,
  output logic tx_done,
  // Modulator side
  output logic chip_out,
  output logic chip_valid,
  // Demodulator side, same clock
  input wire logic rx_chip,
  input wire logic rx_chip_strobe
);
  // Checksum step, one NRZ bit, MSB first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? coder_pkg::CRC_POLY : 16'h0000);
  endfunction
  // Whitening register advance
  function automatic logic [8:0] lfsr_step(input logic [8:0] l);
    lfsr_step = {l[0] ^ l[coder_pkg::LFSR_TAP], l[8:1]};
  endfunction

  // State registers and next values
  coder_pkg::state_e state_r, state_nxt;
  logic [7:0] shreg_r, shreg_nxt;       // Byte shifter
  logic [2:0] bitcnt_r, bitcnt_nxt;     // Bit within byte
  logic [7:0] idx_r, idx_nxt;           // Byte within packet
  logic [7:0] len_r, len_nxt;           // Latched payload length
  logic phase_r, phase_nxt;             // Second chip of a pair
  logic first_r, first_nxt;             // First received chip
  logic [8:0] lfsr_r, lfsr_nxt;
  logic [15:0] crc_r, crc_nxt;
  logic [7:0] rxhi_r, rxhi_nxt;         // Received checksum high byte
  logic [AW-1:0] wptr_r, wptr_nxt;      // Buffer fill pointer
  logic [AW-1:0] hptr_r, hptr_nxt;      // Host read pointer
  logic [15:0] cnt_r, cnt_nxt;          // Chip period counter
  logic [7:0] rate_hi_r, rate_hi_nxt, rate_lo_r, rate_lo_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic pay_r, pay_nxt, ok_r, ok_nxt;
  logic chip_r, chip_nxt, cv_r, cv_nxt, done_r, done_nxt;
  logic busy_r, busy_nxt; // Busy kept in a flop so the port is glitch free
  // Combinational helpers
  logic tick, manch, whiten, wbit, bit_raw, nrz, fin, pass, in_pay;
  logic ram_we, ram_re;
  logic [AW-1:0] ram_raddr;
  logic [7:0] ram_rdata, byte_new;
  logic [8:0] total;
  logic [15:0] rate;

  payload_ram #(.DW(8), .AW(AW)) u_ram (
    .clock(clock),
    .wr_en(ram_we),
    .wr_addr(wptr_r),
    .wr_data(state_r == coder_pkg::ST_RX_BITS ? byte_new : host_wdata),
    .rd_en(ram_re),
    .rd_addr(ram_raddr),
    .rd_data_r(ram_rdata)
  );

  // Decodes shared by both directions
  always_comb begin
    rate = {rate_hi_r, rate_lo_r};
    tick = (cnt_r == 16'h0000);
    manch = cfg.packet_mode && (cfg.dc_balance_select == coder_pkg::DC_MANCHESTER);
    whiten = (cfg.dc_balance_select == coder_pkg::DC_WHITENING);
    wbit = whiten & lfsr_r[0];
    total = {1'b0, len_r} + (cfg.checksum_enable ? coder_pkg::CRC_BYTES : 9'h000);
    in_pay = ({1'b0, idx_r} < {1'b0, len_r});
    // Received bit: first chip of a pair carries the value
    bit_raw = (manch && phase_r) ? first_r : rx_chip;
    nrz = bit_raw ^ wbit;
    byte_new = {shreg_r[6:0], nrz};
    fin = (state_r == coder_pkg::ST_RX_BITS) && rx_chip_strobe && (!manch || phase_r)
          && (bitcnt_r == coder_pkg::LAST_BIT) && ({1'b0, idx_r} + 9'h001 == total);
    pass = ({rxhi_r, byte_new} == ~crc_r);
    ram_we = ((state_r == coder_pkg::ST_RX_BITS) && rx_chip_strobe && (!manch || phase_r)
              && (bitcnt_r == coder_pkg::LAST_BIT) && in_pay)
             || (host_wr && (state_r == coder_pkg::ST_IDLE));
    ram_re = (state_r == coder_pkg::ST_TX_FETCH) || (host_rd && (state_r == coder_pkg::ST_IDLE));
    ram_raddr = (state_r == coder_pkg::ST_TX_FETCH) ? idx_r[AW-1:0] : hptr_r;
  end

  // Next-state logic for the whole sequencer
  always_comb begin
    state_nxt = state_r;
    shreg_nxt = shreg_r;
    bitcnt_nxt = bitcnt_r;
    idx_nxt = idx_r;
    len_nxt = len_r;
    phase_nxt = phase_r;
    first_nxt = first_r;
    lfsr_nxt = lfsr_r;
    crc_nxt = crc_r;
    rxhi_nxt = rxhi_r;
    wptr_nxt = wptr_r;
    hptr_nxt = hptr_r;
    cnt_nxt = tick ? ((rate == 16'h0000) ? 16'h0000 : rate - 16'h0001) : cnt_r - 16'h0001;
    rate_hi_nxt = rate_hi_r;
    rate_lo_nxt = rate_lo_r;
    pay_nxt = pay_r;
    ok_nxt = ok_r;
    chip_nxt = chip_r;
    cv_nxt = 1'b0;
    done_nxt = 1'b0;
    // Register writes and registered read-back
    if (reg_wr && reg_addr == coder_pkg::CHIP_RATE_HIGH_ADDR) begin
      rate_hi_nxt = reg_wdata;
    end
    if (reg_wr && reg_addr == coder_pkg::CHIP_RATE_LOW_ADDR) begin
      rate_lo_nxt = reg_wdata;
    end
    unique case (reg_addr)
      coder_pkg::CHIP_RATE_HIGH_ADDR: rdata_nxt = rate_hi_r;
      coder_pkg::CHIP_RATE_LOW_ADDR: rdata_nxt = rate_lo_r;
      default: rdata_nxt = 8'h00; // Unmapped reads as zero
    endcase
    // Host clears flags first so a same-cycle set wins
    if (flag_clear) begin
      pay_nxt = 1'b0;
      ok_nxt = 1'b0;
    end
    unique case (state_r)
      coder_pkg::ST_IDLE: begin
        // Host buffer traffic only while idle
        if (host_wr) begin
          wptr_nxt = wptr_r + 1'b1;
        end
        if (host_rd) begin
          hptr_nxt = hptr_r + 1'b1;
        end
        idx_nxt = 8'h00;
        bitcnt_nxt = 3'h0;
        phase_nxt = 1'b0;
        lfsr_nxt = coder_pkg::LFSR_PRESET;
        crc_nxt = coder_pkg::CRC_PRESET;
        if (tx_start) begin
          len_nxt = pkt_len;
          state_nxt = coder_pkg::ST_TX_FETCH;
        end else if (rx_start) begin
          len_nxt = pkt_len;
          wptr_nxt = '0;
          hptr_nxt = '0;
          state_nxt = coder_pkg::ST_RX_BITS;
        end
      end
      coder_pkg::ST_TX_FETCH: begin
        // Payload bytes need a memory read first
        state_nxt = coder_pkg::ST_TX_LOAD;
      end
      coder_pkg::ST_TX_LOAD: begin
        // Payload, then inverted checksum high then low
        if (in_pay) begin
          shreg_nxt = ram_rdata;
        end else if (idx_r == len_r) begin
          shreg_nxt = ~crc_r[15:8];
        end else begin
          shreg_nxt = ~crc_r[7:0];
        end
        state_nxt = coder_pkg::ST_TX_BITS;
      end
      coder_pkg::ST_TX_BITS: begin
        if (tick) begin
          cv_nxt = 1'b1;
          if (manch && !phase_r) begin
            chip_nxt = shreg_r[coder_pkg::MSB] ^ wbit;
            phase_nxt = 1'b1;
          end else begin
            // Second chip inverts the first; plain NRZ otherwise
            chip_nxt = (shreg_r[coder_pkg::MSB] ^ wbit) ^ manch;
            phase_nxt = 1'b0;
            if (in_pay) begin
              crc_nxt = crc_step(crc_r, shreg_r[coder_pkg::MSB]);
            end
            lfsr_nxt = lfsr_step(lfsr_r);
            shreg_nxt = {shreg_r[6:0], 1'b0};
            bitcnt_nxt = bitcnt_r + 3'h1;
            if (bitcnt_r == coder_pkg::LAST_BIT) begin
              idx_nxt = idx_r + 8'h01;
              if ({1'b0, idx_r} + 9'h001 < total) begin
                state_nxt = coder_pkg::ST_TX_FETCH;
              end else begin
                done_nxt = 1'b1;
                state_nxt = coder_pkg::ST_IDLE;
              end
            end
          end
        end
      end
      coder_pkg::ST_RX_BITS: begin
        if (rx_chip_strobe) begin
          if (manch && !phase_r) begin
            first_nxt = rx_chip;
            phase_nxt = 1'b1;
          end else begin
            phase_nxt = 1'b0;
            if (in_pay) begin
              crc_nxt = crc_step(crc_r, nrz);
            end
            lfsr_nxt = lfsr_step(lfsr_r);
            shreg_nxt = byte_new;
            bitcnt_nxt = bitcnt_r + 3'h1;
            if (bitcnt_r == coder_pkg::LAST_BIT) begin
              idx_nxt = idx_r + 8'h01;
              if (in_pay) begin
                wptr_nxt = wptr_r + 1'b1;
              end else if (idx_r == len_r) begin
                rxhi_nxt = byte_new;
              end
              if (fin) begin
                state_nxt = coder_pkg::ST_IDLE;
                if (!cfg.checksum_enable) begin
                  pay_nxt = 1'b1;
                end else if (pass) begin
                  pay_nxt = 1'b1;
                  ok_nxt = 1'b1;
                end else if (cfg.crc_fail_keep_fifo) begin
                  pay_nxt = 1'b1;
                end else begin
                  wptr_nxt = '0;
                  hptr_nxt = '0;
                end
              end
            end
          end
        end
      end
      default: state_nxt = coder_pkg::ST_IDLE;
    endcase
    // Busy follows the state that the sequencer enters next
    busy_nxt = (state_nxt != coder_pkg::ST_IDLE);
  end

  // Register stage for all state
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= coder_pkg::ST_IDLE;
      shreg_r <= 8'h00;
      bitcnt_r <= 3'h0;
      idx_r <= 8'h00;
      len_r <= 8'h00;
      phase_r <= 1'b0;
      first_r <= 1'b0;
      lfsr_r <= coder_pkg::LFSR_PRESET;
      crc_r <= coder_pkg::CRC_PRESET;
      rxhi_r <= 8'h00;
      wptr_r <= '0;
      hptr_r <= '0;
      cnt_r <= 16'h0000;
      rate_hi_r <= coder_pkg::CHIP_RATE_HIGH_RST;
      rate_lo_r <= coder_pkg::CHIP_RATE_LOW_RST;
      rdata_r <= 8'h00;
      pay_r <= 1'b0;
      ok_r <= 1'b0;
      chip_r <= 1'b0;
      cv_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shreg_r <= shreg_nxt;
      bitcnt_r <= bitcnt_nxt;
      idx_r <= idx_nxt;
      len_r <= len_nxt;
      phase_r <= phase_nxt;
      first_r <= first_nxt;
      lfsr_r <= lfsr_nxt;
      crc_r <= crc_nxt;
      rxhi_r <= rxhi_nxt;
      wptr_r <= wptr_nxt;
      hptr_r <= hptr_nxt;
      cnt_r <= cnt_nxt;
      rate_hi_r <= rate_hi_nxt;
      rate_lo_r <= rate_lo_nxt;
      rdata_r <= rdata_nxt;
      pay_r <= pay_nxt;
      ok_r <= ok_nxt;
      chip_r <= chip_nxt;
      cv_r <= cv_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Outputs, all from flip-flops
  assign reg_rdata = rdata_r;
  assign host_rdata = ram_rdata;
  assign payload_available_flag = pay_r;
  assign checksum_match_flag = ok_r;
  assign busy = busy_r;
  assign tx_done = done_r;
  assign chip_out = chip_r;
  assign chip_valid = cv_r;

  // Helper: previous emitted chip, for pair checks
  logic last_chip_h, second_h;
  always_ff @(posedge clock) begin
    if (rst) begin
      last_chip_h <= 1'b0;
      second_h <= 1'b0;
    end else if (tick && state_r == coder_pkg::ST_TX_BITS) begin
      last_chip_h <= chip_nxt;
      second_h <= manch && phase_r;
    end
  end

  AST_FAIL_CLEARS: assert property (@(posedge clock) disable iff (rst)
    fin && cfg.checksum_enable && !pass && !cfg.crc_fail_keep_fifo && !flag_clear
    |=> wptr_r == '0 && pay_r == $past(pay_r) && !$rose(ok_r))
    else $error("failed packet not discarded");
  AST_KEEP_ON_FAIL: assert property (@(posedge clock) disable iff (rst)
    fin && cfg.checksum_enable && !pass && cfg.crc_fail_keep_fifo |=> pay_r && !$rose(ok_r))
    else $error("kept packet flags wrong");
  AST_STRIP_CHECKSUM: assert property (@(posedge clock) disable iff (rst)
    state_r == coder_pkg::ST_RX_BITS && !in_pay |-> !ram_we)
    else $error("checksum byte written to buffer");
  AST_MATCH_FLAG: assert property (@(posedge clock) disable iff (rst)
    fin && cfg.checksum_enable && pass |=> ok_r && pay_r)
    else $error("match flag not set");
  AST_MANCH_PAIR: assert property (@(posedge clock) disable iff (rst)
    cv_r && second_h |-> chip_r != $past(last_chip_h))
    else $error("manchester pair not complementary");
  AST_CHIP_TIMING: assert property (@(posedge clock) disable iff (rst)
    cv_r |-> $past(tick) && $past(state_r) == coder_pkg::ST_TX_BITS)
    else $error("chip off the rate tick");
  AST_LFSR_PRESET: assert property (@(posedge clock) disable iff (rst)
    state_r == coder_pkg::ST_IDLE && (tx_start || rx_start) |=> lfsr_r == coder_pkg::LFSR_PRESET)
    else $error("whitening not preset");
  AST_PLAIN_NRZ: assert property (@(posedge clock) disable iff (rst)
    state_r == coder_pkg::ST_TX_BITS && tick && cfg.dc_balance_select == coder_pkg::DC_NONE
    |=> cv_r && chip_r == $past(shreg_r[coder_pkg::MSB]))
    else $error("uncoded chip differs from data");
  AST_CRC_HIGH_FIRST: assert property (@(posedge clock) disable iff (rst)
    state_r == coder_pkg::ST_TX_LOAD && cfg.checksum_enable && idx_r == len_r
    |=> shreg_r == ~$past(crc_r[15:8]))
    else $error("checksum high byte wrong");
  COV_TX_DONE: cover property (@(posedge clock) disable iff (rst) done_r);
  COV_RX_PASS: cover property (@(posedge clock) disable iff (rst) fin && pass);
  COV_RX_FAIL: cover property (@(posedge clock) disable iff (rst) fin && !pass);
  COV_MANCH: cover property (@(posedge clock) disable iff (rst) cv_r && second_h);
endmodule
`default_nettype wire

/* design/payload_ram.sv */
`default_nettype none
module payload_ram #(
  parameter int DW = 8,
  parameter int AW = 6
) (
  // Clock
  input wire logic clock,
  // Write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // Read side, data one cycle after the request
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data_r
);
  // Storage, no reset so it maps onto block memory
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write and registered read
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data_r <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

/* tb/coder_far_end.sv */
`default_nettype none
module coder_far_end (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Chips from the modulator side
  input wire logic chip_out,
  input wire logic chip_valid,
  // Chips toward the demodulator side
  output logic rx_chip,
  output logic rx_chip_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen[$]; // Chips captured in order
  int gap[$]; // Cycles since the chip before
  int cnt = 0; // Running cycle count
  initial begin
    rx_chip = 1'b0;
    rx_chip_strobe = 1'b0;
  end
  // Capture every chip with its spacing
  always @(posedge clock) begin
    cnt++;
    if (rst === 1'b1) begin
      cnt = 0;
    end else if (chip_valid === 1'b1) begin
      seen.push_back(chip_out);
      gap.push_back(cnt);
      cnt = 0;
    end
  end
  // Forget what earlier packets left behind
  task automatic clear();
    seen.delete();
    gap.delete();
  endtask
  // Strobe chips out; idle cycles show the inverse so stale data never matches
  task automatic send(input logic q[$], input int slow);
    foreach (q[i]) begin
      rx_chip <= q[i];
      rx_chip_strobe <= 1'b1;
      @(posedge clock);
      if (slow > 0) begin
        rx_chip_strobe <= 1'b0;
        rx_chip <= ~q[i];
        repeat (slow) @(posedge clock);
      end
    end
    rx_chip_strobe <= 1'b0;
    rx_chip <= ~q[q.size()-1];
  endtask
endmodule
`default_nettype wire

/* tb/test_payload_crc_dc_balance_select_coder.sv */
`default_nettype none
module test_payload_crc_dc_balance_select_coder;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic chips_t[$];
  typedef logic [7:0] bytes_t[$];
  // Short chip period keeps the run brief, yet leaves room for byte fetches
  localparam logic [7:0] RATE = 8'h05;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  coder_pkg::cfg_s cfg = '0;
  logic host_wr = 1'b0;
  logic [7:0] host_wdata = 8'h00;
  logic host_rd = 1'b0;
  logic [7:0] host_rdata;
  logic flag_clear = 1'b0;
  logic payload_available_flag;
  logic checksum_match_flag;
  logic tx_start = 1'b0;
  logic rx_start = 1'b0;
  logic [7:0] pkt_len = 8'h01;
  logic busy;
  logic tx_done;
  logic chip_out;
  logic chip_valid;
  logic rx_chip;
  logic rx_chip_strobe;
  int errors = 0;
  int checks_done = 0;
  // Runs of zeros and ones stress the coders
  bytes_t data = '{8'h00, 8'hff, 8'ha5, 8'h3c, 8'h01};
  always #5 clock = ~clock;
  payload_crc_dc_balance_select_coder dut (.clock, .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .cfg,
    .host_wr, .host_wdata, .host_rd, .host_rdata, .flag_clear, .payload_available_flag,
    .checksum_match_flag, .tx_start, .rx_start, .pkt_len, .busy, .tx_done, .chip_out, .chip_valid,
    .rx_chip, .rx_chip_strobe);
  coder_far_end far (.clock, .rst, .chip_out, .chip_valid, .rx_chip, .rx_chip_strobe);
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Selector field carries one coding at a time
  function automatic coder_pkg::cfg_s mk(logic pm, logic [1:0] sel, logic ce, logic keep);
    return '{pm, sel, ce, keep};
  endfunction
  // Expected chips: checksum over NRZ payload, then whitening or Manchester
  function automatic chips_t code(coder_pkg::cfg_s c, bytes_t d);
    logic [15:0] crc;
    logic [8:0] l;
    logic b;
    chips_t q;
    bytes_t all;
    crc = coder_pkg::CRC_PRESET;
    l = coder_pkg::LFSR_PRESET;
    all = d;
    foreach (d[i]) for (int k = 7; k >= 0; k--) begin
      crc = {crc[14:0], 1'b0} ^ ({16{crc[15] ^ d[i][k]}} & coder_pkg::CRC_POLY);
    end
    if (c.checksum_enable) begin
      all.push_back(~crc[15:8]);
      all.push_back(~crc[7:0]);
    end
    foreach (all[i]) for (int k = 7; k >= 0; k--) begin
      b = all[i][k];
      if (c.dc_balance_select == coder_pkg::DC_WHITENING) begin
        b = b ^ l[0];
        l = {l[0] ^ l[coder_pkg::LFSR_TAP], l[8:1]};
      end
      q.push_back(b);
      if (c.packet_mode && c.dc_balance_select == coder_pkg::DC_MANCHESTER) q.push_back(~b);
    end
    return q;
  endfunction
  task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    @(posedge clock);
    #1 check("reg_rdata", reg_rdata, exp);
  endtask
  // Reset for 12 cycles, optionally program the short chip period
  task automatic do_reset(input logic set_rate);
    @(posedge clock);
    rst <= 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    if (set_rate) begin
      reg_write(coder_pkg::CHIP_RATE_HIGH_ADDR, 8'h00);
      reg_write(coder_pkg::CHIP_RATE_LOW_ADDR, RATE);
    end
    far.clear();
  endtask
  // Reset values, write back, unmapped place refused
  task automatic test_registers();
    reg_read(coder_pkg::CHIP_RATE_HIGH_ADDR, coder_pkg::CHIP_RATE_HIGH_RST);
    reg_read(coder_pkg::CHIP_RATE_LOW_ADDR, coder_pkg::CHIP_RATE_LOW_RST);
    reg_write(coder_pkg::CHIP_RATE_HIGH_ADDR, 8'h5a);
    reg_read(coder_pkg::CHIP_RATE_HIGH_ADDR, 8'h5a);
    reg_write(7'h05, 8'h77);
    reg_read(7'h05, 8'h00);
    reg_write(coder_pkg::CHIP_RATE_LOW_ADDR, 8'hc3);
    reg_read(coder_pkg::CHIP_RATE_LOW_ADDR, 8'hc3);
  endtask
  // Load the buffer, send one packet, compare every chip and each spacing after the first
  task automatic tx_run(input coder_pkg::cfg_s c);
    chips_t exp;
    int n;
    do_reset(1'b1);
    @(posedge clock);
    cfg <= c;
    foreach (data[i]) begin
      host_wr <= 1'b1;
      host_wdata <= data[i];
      @(posedge clock);
    end
    host_wr <= 1'b0;
    tx_start <= 1'b1;
    pkt_len <= 8'(data.size());
    @(posedge clock);
    tx_start <= 1'b0;
    n = 0;
    // The period running at reset keeps the reset rate, so the first chip may wait that long
    while (tx_done !== 1'b1 && n < 10000) begin
      @(posedge clock);
      n++;
    end
    // Let the far end capture the final chip of this edge first
    #1;
    exp = code(c, data);
    check("tx_done_seen", n < 10000, 1'b1);
    check("tx_chip_count", far.seen.size(), exp.size());
    foreach (exp[i]) check("tx_chip", far.seen[i], exp[i]);
    for (int i = 1; i < far.gap.size(); i++) check("tx_chip_gap", far.gap[i], RATE);
  endtask
  // Every selector code in packet mode with checksum, plus Manchester without packet mode and no coding without checksum
  task automatic test_tx_modes();
    tx_run(mk(1'b1, coder_pkg::DC_NONE, 1'b1, 1'b0));
    tx_run(mk(1'b1, coder_pkg::DC_MANCHESTER, 1'b1, 1'b0));
    tx_run(mk(1'b0, coder_pkg::DC_MANCHESTER, 1'b1, 1'b0));
    tx_run(mk(1'b1, coder_pkg::DC_WHITENING, 1'b1, 1'b0));
    tx_run(mk(1'b1, 2'h3, 1'b1, 1'b0));
    tx_run(mk(1'b1, coder_pkg::DC_NONE, 1'b0, 1'b0));
  endtask
  // Receive one packet, optionally with a flipped chip, then judge flags and buffer
  task automatic rx_run(input coder_pkg::cfg_s c, input logic bad, input logic pay, input logic ok, input int slow);
    chips_t q;
    @(posedge clock);
    cfg <= c;
    flag_clear <= 1'b1;
    @(posedge clock);
    flag_clear <= 1'b0;
    rx_start <= 1'b1;
    pkt_len <= 8'(data.size());
    @(posedge clock);
    rx_start <= 1'b0;
    q = code(c, data);
    if (bad) q[2] = ~q[2];
    far.send(q, slow);
    @(posedge clock);
    #1 check("rx_busy", busy, 1'b0);
    check("payload_available_flag", payload_available_flag, pay);
    check("checksum_match_flag", checksum_match_flag, ok);
    if (pay) begin
      foreach (data[i]) begin
        @(posedge clock);
        host_rd <= 1'b1;
        @(posedge clock);
        host_rd <= 1'b0;
        // A flipped third chip lands in bit 5 of the first byte
        #1 check("rx_byte", host_rdata, data[i] ^ ((bad && i == 0) ? 8'h20 : 8'h00));
      end
    end
    // Fill pointer stops after the payload, or is back at 0 after a discard
    @(posedge clock);
    host_wr <= 1'b1;
    host_wdata <= 8'h99;
    @(posedge clock);
    host_wr <= 1'b0;
    host_rd <= 1'b1;
    @(posedge clock);
    host_rd <= 1'b0;
    #1 check("rx_after_payload", host_rdata, 8'h99);
  endtask
  task automatic test_rx_cases();
    rx_run(mk(1'b1, coder_pkg::DC_NONE, 1'b1, 1'b0), 1'b0, 1'b1, 1'b1, 0);
    rx_run(mk(1'b1, coder_pkg::DC_WHITENING, 1'b1, 1'b0), 1'b0, 1'b1, 1'b1, 2);
    rx_run(mk(1'b1, coder_pkg::DC_MANCHESTER, 1'b1, 1'b0), 1'b0, 1'b1, 1'b1, 1);
    rx_run(mk(1'b1, coder_pkg::DC_NONE, 1'b1, 1'b1), 1'b1, 1'b1, 1'b0, 0);
    rx_run(mk(1'b1, coder_pkg::DC_NONE, 1'b1, 1'b0), 1'b1, 1'b0, 1'b0, 1);
    rx_run(mk(1'b1, coder_pkg::DC_NONE, 1'b0, 1'b0), 1'b0, 1'b1, 1'b0, 0);
  endtask
  // Main sequence
  initial begin
    do_reset(1'b0);
    test_registers();
    test_tx_modes();
    test_rx_cases();
    test_done();
  end
  // Cut a hang short well beyond the expected run length
  initial begin
    repeat (70000) @(posedge clock);
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
